// ===== output_divider.sv
// one post-scale divider with high/low time counts
// assumes in_tick is a one-cycle pulse per rising edge of its source clock
`timescale 1ns/100ps
`default_nettype none
module output_divider
  import pll_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic div_reset,
  // source clock events
  input wire logic in_tick,
  // duty-cycle setting
  input wire logic [DIV_W-1:0] high_count,
  input wire logic [DIV_W-1:0] low_count,
  // divided clock
  output logic out_level,
  output logic out_tick
);

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] hi_eff;
  logic [DIV_W-1:0] lo_eff;
  logic [DIV_W-1:0] ratio;

  // even split reaches 512, any other split stops at 256 in total
  always_comb begin
    hi_eff = limit_div(high_count, PHASE_MAX);
    lo_eff = limit_div(low_count, PHASE_MAX);
    if (hi_eff != lo_eff) begin
      hi_eff = limit_div(hi_eff, DIV_MAX_UNEVEN - DIV_MIN);
      lo_eff = limit_div(lo_eff, DIV_MAX_UNEVEN - hi_eff);
    end
    ratio = hi_eff + lo_eff;
  end

  // each phase counts its own number of source edges
  always_ff @(posedge ref_clk) begin
    if (div_reset) begin
      cnt_reg <= '0;
      out_level <= 1'b0;
      out_tick <= 1'b0;
    end else begin
      out_tick <= 1'b0;
      if (in_tick) begin
        if (out_level) begin
          if (cnt_reg + DIV_MIN >= hi_eff) begin
            cnt_reg <= '0;
            out_level <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + DIV_MIN;
          end
        end else if (cnt_reg + DIV_MIN >= lo_eff) begin
          cnt_reg <= '0;
          out_level <= 1'b1;
          out_tick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + DIV_MIN;
        end
      end
    end
  end

  a_ratio_bounded: assert property (@(posedge ref_clk) disable iff (div_reset)
    ratio >= 10'h002 && ratio <= DIV_MAX)
    else $error("divider ratio out of range");

endmodule : output_divider
`default_nettype wire

// ===== pll_clock_control.sv
// control logic of a clock-synthesis loop: dividers, phase detector gate,
// lock, loss detection and reference switchover
// assumes references, oscillator and control pins are asynchronous to
// ref_clk and much slower than it; cascade straps are stable at reset
`timescale 1ns/100ps
`default_nettype none
module pll_clock_control
  import pll_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // reference and oscillator inputs
  input wire logic primary_ref_in,
  input wire logic backup_ref_in,
  input wire logic loop_oscillator,
  // loop control pins
  input wire logic async_pll_reset,
  input wire logic phase_detector_enable,
  input wire logic manual_switch_request,
  // divider configuration
  input wire logic [DIV_W-1:0] prescale_div,
  input wire logic [DIV_W-1:0] feedback_div,
  input wire logic [NUM_OUT-1:0][DIV_W-1:0] out_high_count,
  input wire logic [NUM_OUT-1:0][DIV_W-1:0] out_low_count,
  input wire logic [NUM_OUT-2:0] cascade_enable,
  // reference path and switchover status
  output logic gated_ref_clock,
  output logic ref_mux_select,
  output logic selected_ref_indicator,
  output logic primary_missing,
  output logic backup_missing,
  // loop status and correction
  output logic phase_up,
  output logic phase_down,
  output logic osc_nominal,
  output logic locked,
  // divided clocks
  output logic [NUM_OUT-1:0] global_clock_net,
  output logic ext_clk_out
);

  logic [SYN_W-1:0] sync_meta_reg;
  logic [SYN_W-1:0] sync_reg;
  logic [SYN_W-1:0] sync_prev_reg;
  logic [1:0] ref_edge;
  logic pri_fall;
  logic bkp_fall;
  logic osc_rise;
  logic man_rise;
  logic pll_rst;
  logic pde;
  logic div_rst;

  // every reference, oscillator and control pin passes two flops; only the second stage and its one-cycle delayed copy are looked at
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_meta_reg <= '0;
      sync_reg <= '0;
      sync_prev_reg <= '0;
    end else begin
      sync_meta_reg <= {manual_switch_request, phase_detector_enable,
        async_pll_reset, loop_oscillator, backup_ref_in, primary_ref_in};
      sync_reg <= sync_meta_reg;
      sync_prev_reg <= sync_reg;
    end
  end

  assign ref_edge = sync_reg[SYN_BKP:SYN_PRI] ^ sync_prev_reg[SYN_BKP:SYN_PRI];
  assign pri_fall = ~sync_reg[SYN_PRI] & sync_prev_reg[SYN_PRI];
  assign bkp_fall = ~sync_reg[SYN_BKP] & sync_prev_reg[SYN_BKP];
  assign osc_rise = sync_reg[SYN_OSC] & ~sync_prev_reg[SYN_OSC];
  assign man_rise = sync_reg[SYN_MAN] & ~sync_prev_reg[SYN_MAN];
  assign pll_rst = sync_reg[SYN_ARST];
  assign pde = sync_reg[SYN_PDE];
  assign div_rst = rst | pll_rst;

  // loss detection: no edge for two reference periods
  logic [MISS_CNT_W-1:0] miss_cnt_reg [2];
  logic [1:0] missing_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      miss_cnt_reg[0] <= '0;
      miss_cnt_reg[1] <= '0;
      missing_reg <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ref_edge[i]) begin
          miss_cnt_reg[i] <= '0;
          // first edge after a stall only restarts the window
          if (miss_cnt_reg[i] != MISS_WINDOW) begin
            missing_reg[i] <= 1'b0;
          end
        end else if (miss_cnt_reg[i] != MISS_WINDOW) begin
          miss_cnt_reg[i] <= miss_cnt_reg[i] + 1'b1;
        end else begin
          missing_reg[i] <= 1'b1;
        end
      end
    end
  end

  assign primary_missing = missing_reg[SEL_PRIMARY];
  assign backup_missing = missing_reg[SEL_BACKUP];

  // switchover machine
  switch_state_e state_reg;
  logic sel_reg;
  logic gate_open_reg;
  logic gated_reg;
  logic gated_prev_reg;
  logic osc_rise_reg;
  logic cur_missing;
  logic oth_missing;
  logic old_fall;
  logic new_fall;

  assign cur_missing = missing_reg[sel_reg];
  assign oth_missing = missing_reg[~sel_reg];
  assign old_fall = (sel_reg == SEL_BACKUP) ? bkp_fall : pri_fall;
  assign new_fall = (sel_reg == SEL_BACKUP) ? pri_fall : bkp_fall;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= SW_IDLE;
      sel_reg <= SEL_PRIMARY;
      gate_open_reg <= 1'b1;
    end else begin
      case (state_reg)
        SW_IDLE: begin
          // a request during a switch is dropped, not queued
          if (man_rise || (cur_missing && !oth_missing)) begin
            state_reg <= SW_GATE;
          end
        end
        SW_GATE: begin
          // a dead reference has no falling edge left to wait for
          if (old_fall || cur_missing) begin
            gate_open_reg <= 1'b0;
            state_reg <= SW_MOVE;
          end
        end
        SW_MOVE: begin
          if (new_fall && !oth_missing) begin
            sel_reg <= ~sel_reg;
            gate_open_reg <= 1'b1;
            state_reg <= SW_IDLE;
          end
        end
        default: begin
          state_reg <= SW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gated_reg <= 1'b0;
      gated_prev_reg <= 1'b0;
      osc_rise_reg <= 1'b0;
    end else begin
      gated_reg <= gate_open_reg & sync_reg[sel_reg];
      gated_prev_reg <= gated_reg;
      // feedback edge takes the same extra stage as the gated reference,
      // else an in-phase oscillator would always read as one cycle early
      osc_rise_reg <= osc_rise;
    end
  end

  assign gated_ref_clock = gated_reg;
  assign ref_mux_select = sel_reg;
  assign selected_ref_indicator = sel_reg;

  // pre-scale and feedback dividers, frequency only
  logic [DIV_W-1:0] pre_cnt_reg;
  logic [DIV_W-1:0] fb_cnt_reg;
  logic ref_tick_reg;
  logic fb_tick_reg;

  always_ff @(posedge ref_clk) begin
    if (div_rst) begin
      pre_cnt_reg <= '0;
      ref_tick_reg <= 1'b0;
    end else begin
      ref_tick_reg <= 1'b0;
      if (gated_reg && !gated_prev_reg) begin
        // plain modulo count, no duty control
        if (pre_cnt_reg + DIV_MIN >= limit_div(prescale_div, DIV_MAX)) begin
          pre_cnt_reg <= '0;
          ref_tick_reg <= 1'b1;
        end else begin
          pre_cnt_reg <= pre_cnt_reg + DIV_MIN;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (div_rst) begin
      fb_cnt_reg <= '0;
      fb_tick_reg <= 1'b0;
    end else begin
      fb_tick_reg <= 1'b0;
      if (osc_rise_reg) begin
        if (fb_cnt_reg + DIV_MIN >= limit_div(feedback_div, DIV_MAX)) begin
          fb_cnt_reg <= '0;
          fb_tick_reg <= 1'b1;
        end else begin
          fb_cnt_reg <= fb_cnt_reg + DIV_MIN;
        end
      end
    end
  end

  // phase detector: the earlier tick opens a correction until the other
  logic up_reg;
  logic down_reg;

  always_ff @(posedge ref_clk) begin
    if (div_rst) begin
      up_reg <= 1'b0;
      down_reg <= 1'b0;
    end else if (ref_tick_reg && !fb_tick_reg) begin
      if (down_reg) begin
        down_reg <= 1'b0;
      end else begin
        up_reg <= 1'b1;
      end
    end else if (fb_tick_reg && !ref_tick_reg) begin
      if (up_reg) begin
        up_reg <= 1'b0;
      end else begin
        down_reg <= 1'b1;
      end
    end
  end

  // the gate only hides corrections; the oscillator keeps its last control
  always_ff @(posedge ref_clk) begin
    if (div_rst) begin
      phase_up <= 1'b0;
      phase_down <= 1'b0;
      osc_nominal <= 1'b1;
    end else begin
      phase_up <= up_reg & pde;
      phase_down <= down_reg & pde;
      osc_nominal <= 1'b0;
    end
  end

  // lock: a run of reference periods each holding exactly one feedback tick
  logic [1:0] pend_reg;
  logic [4:0] lock_cnt_reg;
  logic one_fb;

  assign one_fb = (pend_reg == 2'h1 && !fb_tick_reg) ||
    (pend_reg == 2'h0 && fb_tick_reg);

  always_ff @(posedge ref_clk) begin
    if (div_rst) begin
      pend_reg <= '0;
      lock_cnt_reg <= '0;
      locked <= 1'b0;
    end else begin
      if (ref_tick_reg) begin
        pend_reg <= '0;
        if (!one_fb || up_reg || down_reg) begin
          lock_cnt_reg <= '0;
        end else if (lock_cnt_reg != LOCK_PERIODS) begin
          lock_cnt_reg <= lock_cnt_reg + 1'b1;
        end
      end else if (fb_tick_reg && pend_reg != 2'h3) begin
        pend_reg <= pend_reg + 1'b1;
      end
      locked <= (lock_cnt_reg == LOCK_PERIODS);
    end
  end

  // cascade straps are taken once after reset and then frozen
  logic [NUM_OUT-2:0] cascade_reg;
  logic cfg_loaded_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cascade_reg <= '0;
      cfg_loaded_reg <= 1'b0;
    end else if (!cfg_loaded_reg) begin
      cascade_reg <= cascade_enable;
      cfg_loaded_reg <= 1'b1;
    end
  end

  // post-scale dividers
  logic [NUM_OUT-1:0] div_level;
  logic [NUM_OUT-1:0] div_tick;

  for (genvar g = 0; g < NUM_OUT; g++) begin : gen_div
    logic src_tick;
    if (g == 0) begin : gen_first
      assign src_tick = osc_rise;
    end else begin : gen_chain
      // cascaded stages multiply their ratios
      assign src_tick = cascade_reg[g-1] ? div_tick[g-1] : osc_rise;
    end
    output_divider u_div (
      .ref_clk(ref_clk),
      .div_reset(div_rst),
      .in_tick(src_tick),
      .high_count(out_high_count[g]),
      .low_count(out_low_count[g]),
      .out_level(div_level[g]),
      .out_tick(div_tick[g])
    );
  end

  assign global_clock_net = div_level;
  assign ext_clk_out = div_level[0];

  a_missing_sets: assert property (@(posedge ref_clk) disable iff (rst)
    (miss_cnt_reg[0] == MISS_WINDOW && !ref_edge[0]) |=> primary_missing)
    else $error("primary loss not flagged");

  a_mux_on_fall: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(sel_reg) |-> $past(new_fall) && !$past(oth_missing))
    else $error("mux moved off a new-reference falling edge");

  a_gate_before_move: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(sel_reg) |-> $past(state_reg) == SW_MOVE && !$past(gate_open_reg))
    else $error("mux moved while reference gate open");

  a_auto_switch_start: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == SW_IDLE && cur_missing && !oth_missing) |=>
      state_reg == SW_GATE)
    else $error("automatic switchover did not start");

  a_reset_clears_out: assert property (@(posedge ref_clk) disable iff (rst)
    pll_rst |=> !locked && global_clock_net == '0 && osc_nominal)
    else $error("loop reset did not clear outputs and lock");

  a_pd_gate_off: assert property (@(posedge ref_clk) disable iff (rst)
    !pde |=> !phase_up && !phase_down)
    else $error("correction pulse while detector disabled");

  a_cascade_frozen: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_loaded_reg |=> $stable(cascade_reg))
    else $error("cascade setting changed at run time");

  a_lock_qualified: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(locked) |-> $past(lock_cnt_reg) == LOCK_PERIODS)
    else $error("lock raised without a full run");

  a_manual_no_back: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == SW_IDLE && !man_rise && !cur_missing) |=> $stable(sel_reg))
    else $error("selection changed without a request");

endmodule : pll_clock_control
`default_nettype wire

// ===== pll_clock_control_tb.sv
// self-checking bench for the clock-synthesis control block
// assumes the reference model drives clocks with a 40 ns period
`timescale 1ns/100ps
`default_nettype none
module pll_clock_control_tb
  import pll_ctrl_pkg::*;
;
  logic ref_clk, rst, arst, pde, man, pri_run, bkp_run;
  logic pri, bkp, osc;
  logic [DIV_W-1:0] pre_div, fb_div;
  logic [NUM_OUT-1:0][DIV_W-1:0] hi_cnt, lo_cnt;
  logic [NUM_OUT-2:0] casc;
  logic gated, sel, ind, pmiss, bmiss, up, dn, nom, lck, ext;
  logic [NUM_OUT-1:0] gnet;
  int fail_count = 0;
  int checks_done = 0;
  int n, h, l, any_pd;
  logic sel_was;
  int exp_h[NUM_OUT] = '{20, 40, 30, 10, 50};
  int exp_l[NUM_OUT] = '{20, 40, 10, 10, 40};

  ref_source_model model (.pri_run(pri_run), .bkp_run(bkp_run),
    .ref_mux_select(sel), .primary_ref_in(pri), .backup_ref_in(bkp),
    .loop_oscillator(osc));

  pll_clock_control DUT (.ref_clk(ref_clk), .rst(rst),
    .primary_ref_in(pri), .backup_ref_in(bkp), .loop_oscillator(osc),
    .async_pll_reset(arst), .phase_detector_enable(pde),
    .manual_switch_request(man), .prescale_div(pre_div),
    .feedback_div(fb_div), .out_high_count(hi_cnt), .out_low_count(lo_cnt),
    .cascade_enable(casc), .gated_ref_clock(gated), .ref_mux_select(sel),
    .selected_ref_indicator(ind), .primary_missing(pmiss),
    .backup_missing(bmiss), .phase_up(up), .phase_down(dn),
    .osc_nominal(nom), .locked(lck), .global_clock_net(gnet),
    .ext_clk_out(ext));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc

  function automatic logic probe(input int which);
    case (which)
      0: return lck;
      1: return pmiss;
      2: return sel;
      default: return bmiss;
    endcase
  endfunction : probe

  // bounded wait; cnt reports how many cycles it took
  task automatic wait_lvl(input int which, input logic val, input int lim,
                          output int cnt);
    cnt = 0;
    while (probe(which) !== val && cnt < lim) begin
      cyc(1);
      cnt++;
    end
  endtask : wait_lvl

  // high and low spans of one divided clock, in ref_clk cycles
  task automatic measure(input int k, output int hc, output int lc);
    int c;
    c = 0;
    while (gnet[k] !== 1'b0 && c < 400) begin cyc(1); c++; end
    while (gnet[k] !== 1'b1 && c < 800) begin cyc(1); c++; end
    hc = 0;
    while (gnet[k] === 1'b1 && hc < 1000) begin cyc(1); hc++; end
    lc = 0;
    while (gnet[k] === 1'b0 && lc < 1000) begin cyc(1); lc++; end
  endtask : measure

  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    arst = 1'b1;
    pde = 1'b1;
    man = 1'b0;
    pri_run = 1'b1;
    bkp_run = 1'b1;
    pre_div = 10'h001;
    fb_div = 10'h001;
    hi_cnt = {10'h005, 10'h001, 10'h003, 10'h001, 10'h002};
    lo_cnt = {10'h004, 10'h001, 10'h001, 10'h001, 10'h002};
    casc = 4'h1;
    repeat (4) @(posedge ref_clk);
    #1;
    check("nominal in reset", nom, 1'b1);
    check("select in reset", sel, 1'b0);
    check("missing in reset", {pmiss, bmiss}, 2'b00);
    rst <= 1'b0;
    cyc(20);
    // loop reset released only once both references are running
    arst <= 1'b0;
    cyc(2);
    // strap changes after capture must not alter the cascade
    casc <= 4'h0;
    wait_lvl(0, 1'b1, 3000, n);
    check("lock acquired", lck, 1'b1);
    check("nominal released", nom, 1'b0);
    for (int k = 0; k < NUM_OUT; k++) begin
      measure(k, h, l);
      check("divided high span", h, exp_h[k]);
      check("divided low span", l, exp_l[k]);
    end
    check("external output", ext, gnet[0]);
    // detector gated while a feedback mismatch forces corrections
    pde <= 1'b0;
    cyc(4);
    fb_div <= 10'h002;
    any_pd = 0;
    repeat (200) begin
      cyc(1);
      if (up !== 1'b0 || dn !== 1'b0) any_pd++;
    end
    check("gated corrections", any_pd, 0);
    pde <= 1'b1;
    cyc(5);
    check("corrections resume", up, 1'b1);
    fb_div <= 10'h001;
    // loop reset mid-run leaves switchover state alone
    sel_was = sel;
    arst <= 1'b1;
    cyc(4);
    check("reset lock", lck, 1'b0);
    check("reset nominal", nom, 1'b1);
    cyc(20);
    check("reset outputs", {ext, gnet}, 6'h00);
    check("reset keeps select", sel, sel_was);
    arst <= 1'b0;
    wait_lvl(0, 1'b1, 3000, n);
    check("relock", lck, 1'b1);
    // primary loss: flag after about two periods, then backup
    // stop just after a falling edge so the window start is known
    @(negedge pri);
    cyc(1);
    pri_run <= 1'b0;
    wait_lvl(1, 1'b1, 60, n);
    check("primary loss window", n >= 20 && n <= 30, 1'b1);
    wait_lvl(2, 1'b1, 60, n);
    check("auto to backup", sel, 1'b1);
    check("indicator backup", ind, 1'b1);
    check("backup flag quiet", bmiss, 1'b0);
    pri_run <= 1'b1;
    wait_lvl(1, 1'b0, 60, n);
    check("primary flag clears", pmiss, 1'b0);
    check("no return on recovery", sel, 1'b1);
    // backup loss: switch back again
    bkp_run <= 1'b0;
    wait_lvl(3, 1'b1, 60, n);
    check("backup flag", bmiss, 1'b1);
    wait_lvl(2, 1'b0, 60, n);
    check("auto to primary", {sel, ind}, 2'b00);
    bkp_run <= 1'b1;
    wait_lvl(3, 1'b0, 60, n);
    check("backup flag clears", bmiss, 1'b0);
    cyc(20);
    // manual request, held well over three reference periods
    man <= 1'b1;
    wait_lvl(2, 1'b1, 100, n);
    check("manual to backup", {sel, ind}, 2'b11);
    // gated reference now follows the backup: 8 level changes in 160 ns
    sel_was = gated;
    any_pd = 0;
    repeat (40) begin
      cyc(1);
      if (gated !== sel_was) any_pd++;
      sel_was = gated;
    end
    check("gated follows backup", any_pd, 8);
    man <= 1'b0;
    cyc(100);
    check("fall keeps backup", sel, 1'b1);
    check("manual flags quiet", {pmiss, bmiss}, 2'b00);
    man <= 1'b1;
    wait_lvl(2, 1'b0, 100, n);
    check("manual to primary", {sel, ind}, 2'b00);
    cyc(40);
    man <= 1'b0;
    cyc(20);
    tally_and_finish();
  end
endmodule : pll_clock_control_tb
`default_nettype wire

// ===== pll_ctrl_pkg.sv
// shared constants, types and helpers for the clock-synthesis control block
// assumes a single 250 MHz ref_clk that oversamples every reference and the
// oscillator output
`default_nettype none
package pll_ctrl_pkg;

  // clock rate and timing
  localparam int CLK_PERIOD_PS = 4000;
  // nominal period of the slower reference, used to size the loss window
  localparam int REF_PERIOD_NS = 40;
  // two reference periods, rounded down to whole ref_clk cycles
  localparam int MISS_WINDOW_CYCLES = (2 * REF_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int MISS_CNT_W = $clog2(MISS_WINDOW_CYCLES + 1);
  localparam logic [MISS_CNT_W-1:0] MISS_WINDOW =
    MISS_CNT_W'(MISS_WINDOW_CYCLES);

  // divider ranges and widths
  localparam int DIV_W = 10;
  localparam logic [DIV_W-1:0] DIV_MIN = 10'h001;
  localparam logic [DIV_W-1:0] DIV_MAX = 10'h200;
  localparam logic [DIV_W-1:0] DIV_MAX_UNEVEN = 10'h100;
  localparam logic [DIV_W-1:0] PHASE_MAX = 10'h100;
  localparam int NUM_OUT = 5;

  // lock qualification
  localparam logic [4:0] LOCK_PERIODS = 5'h10;

  // positions in the synchroniser vector
  localparam int SYN_PRI = 0;
  localparam int SYN_BKP = 1;
  localparam int SYN_OSC = 2;
  localparam int SYN_ARST = 3;
  localparam int SYN_PDE = 4;
  localparam int SYN_MAN = 5;
  localparam int SYN_W = 6;

  // reference selection values
  localparam logic SEL_PRIMARY = 1'b0;
  localparam logic SEL_BACKUP = 1'b1;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_GATE = 2'b01,
    SW_MOVE = 2'b11
  } switch_state_e;

  // clamp a divide setting into 1..limit; zero reads as one
  function automatic logic [DIV_W-1:0] limit_div(
    input logic [DIV_W-1:0] v,
    input logic [DIV_W-1:0] limit
  );
    if (v < DIV_MIN) begin
      return DIV_MIN;
    end else if (v > limit) begin
      return limit;
    end
    return v;
  endfunction : limit_div

endpackage : pll_ctrl_pkg
`default_nettype wire

// ===== ref_source_model.sv
// system-side model: two free-running references and a loop oscillator
// assumes the block selects a reference through ref_mux_select
`timescale 1ns/100ps
`default_nettype none
module ref_source_model (
  // run controls
  input wire logic pri_run,
  input wire logic bkp_run,
  // mux selection from the block
  input wire logic ref_mux_select,
  // clocks towards the block
  output logic primary_ref_in,
  output logic backup_ref_in,
  output logic loop_oscillator
);
  // both references share one rate so loss sensing stays in range
  localparam real HALF_NS = 20.0;

  // odd start offsets keep every edge off the ref_clk sampling edge
  initial begin
    primary_ref_in = 1'b0;
    #1.3;
    forever begin
      #(HALF_NS);
      primary_ref_in = pri_run ? ~primary_ref_in : 1'b0;
    end
  end

  initial begin
    backup_ref_in = 1'b0;
    #7.1;
    forever begin
      #(HALF_NS);
      backup_ref_in = bkp_run ? ~backup_ref_in : 1'b0;
    end
  end

  // ideal oscillator: exact multiple of the selected input at unit ratios
  assign loop_oscillator = ref_mux_select ? backup_ref_in : primary_ref_in;
endmodule : ref_source_model
`default_nettype wire
